// >>> rtl/cmpc_current_mode_pwm.sv
// Timing and sequencing core of a fixed-frequency current-mode controller.
// Assumes comparators arrive as asynchronous digital levels and the
// analog ramp/sense path is outside; supplyOk is the lockout state.

`timescale 1ns/10ps
`include "cmpc_params.svh"

module cmpc_current_mode_pwm
    import cmpc_pkg::*;
#(
    parameter int PERIOD_CYC   = `CMPC_PERIOD_CYC,
    parameter int SS_STEP_CYC  = `CMPC_SS_STEP_CYC,
    parameter int SS_TOTAL_CYC = `CMPC_SS_TOTAL_CYC,
    parameter int JIT_HALF_CYC = `CMPC_JIT_HALF_CYC
) (
    input  wire logic          clock,
    input  wire logic          nrst,
    input  wire logic          supplyOk,
    input  wire logic          restartReq,
    input  wire logic          burstMode,
    input  wire cmpc_cmp_type  cmpIn,
    output logic               gateDrive,
    output logic               rampReset,
    output logic               senseEnable,
    output logic [5:0]         softStartLevel,
    output logic [15:0]        senseGainX100,
    output cmpc_stat_type      status
);

    // Jitter swing scales with the period actually built, not the nominal one
    localparam int DEV_CYC = (PERIOD_CYC * `CMPC_JITTER_PCT) / 100;
    localparam int PMAX    = PERIOD_CYC + DEV_CYC;

    initial begin
        if (PERIOD_CYC < 16 || PERIOD_CYC > 60000 || SS_STEP_CYC < 1 ||
            SS_TOTAL_CYC < SS_STEP_CYC || JIT_HALF_CYC < 1 || JIT_HALF_CYC > 100000000) begin
            $error("cmpc_current_mode_pwm: unsupported parameter values");
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // two-stage synchronising
    logic [5:0] syncA;
    logic [5:0] syncB;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            syncA <= 6'h00;
            syncB <= 6'h00;
        end else begin
            syncA <= {supplyOk, restartReq, burstMode, cmpIn};
            syncB <= syncA;
        end
    end

    logic supplyS;
    logic restartS;
    logic burstS;
    cmpc_cmp_type cmpS;
    assign supplyS  = syncB[5];
    assign restartS = syncB[4];
    assign burstS   = syncB[3];
    assign cmpS     = cmpc_cmp_type'(syncB[2:0]);

    // ------------------------------------------------------------
    // Power and soft-start sequencing
    // ------------------------------------------------------------
    cmpc_state_type state;
    logic [31:0]    ssStepCnt;
    logic [31:0]    ssTotalCnt;
    logic [5:0]     ssStep;
    logic           restartD;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            restartD <= 1'b0;
        end else begin
            restartD <= restartS;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state      <= CMPC_OFF;
            ssStepCnt  <= 32'h0;
            ssTotalCnt <= 32'h0;
            ssStep     <= 6'h00;
        end else if (!supplyS) begin
            state      <= CMPC_OFF;
            ssStepCnt  <= 32'h0;
            ssTotalCnt <= 32'h0;
            ssStep     <= 6'h00;
        end else if (restartS && !restartD) begin
            state      <= CMPC_SOFT;
            ssStepCnt  <= 32'h0;
            ssTotalCnt <= 32'h0;
            ssStep     <= 6'h00;
        end else begin
            unique case (state)
                CMPC_OFF: begin
                    state <= CMPC_SOFT;
                end
                CMPC_SOFT: begin
                    if (ssStepCnt == 32'(SS_STEP_CYC - 1)) begin
                        ssStepCnt <= 32'h0;
                        if (ssStep != 6'(`CMPC_SS_STEPS)) begin
                            ssStep <= ssStep + 6'h01;
                        end
                    end else begin
                        ssStepCnt <= ssStepCnt + 32'h1;
                    end
                    if (ssTotalCnt == 32'(SS_TOTAL_CYC - 1)) begin
                        state <= CMPC_RUN;
                    end else begin
                        ssTotalCnt <= ssTotalCnt + 32'h1;
                    end
                end
                CMPC_RUN: begin
                    state <= CMPC_RUN;
                end
            endcase
        end
    end

    logic softActive;
    logic running;
    assign softActive = (state == CMPC_SOFT);
    assign running    = (state != CMPC_OFF);

    // ------------------------------------------------------------
    // Frequency jitter
    // ------------------------------------------------------------
    // Triangle sweep; one up plus one down leg forms the 4 ms cycle
    logic [31:0] jitCnt;
    logic        jitUp;
    logic [15:0] jitOffset;
    logic [15:0] periodLen;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            jitCnt <= 32'h0;
            jitUp  <= 1'b1;
        end else if (state != CMPC_RUN) begin
            jitCnt <= 32'h0;
            jitUp  <= 1'b1;
        end else if (jitCnt == 32'(JIT_HALF_CYC - 1)) begin
            jitCnt <= 32'h0;
            jitUp  <= ~jitUp;
        end else begin
            jitCnt <= jitCnt + 32'h1;
        end
    end

    // Offset spans 0..2*DEV-1 across a leg; period = nominal - DEV + offset
    assign jitOffset = (state == CMPC_RUN) ?
        16'(((jitUp ? jitCnt : 32'(JIT_HALF_CYC - 1) - jitCnt) * 32'(2 * DEV_CYC)) / 32'(JIT_HALF_CYC))
        : 16'(DEV_CYC);
    assign periodLen = 16'(PERIOD_CYC - DEV_CYC) + jitOffset;

    // ------------------------------------------------------------
    // Oscillator
    // ------------------------------------------------------------
    logic [15:0] phase;
    logic [15:0] curPeriod;
    logic        cycleStart;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase     <= 16'h0000;
            curPeriod <= 16'(PERIOD_CYC);
        end else if (!running) begin
            phase     <= 16'h0000;
            curPeriod <= 16'(PERIOD_CYC);
        end else if (phase == curPeriod - 16'h0001) begin
            phase     <= 16'h0000;
            curPeriod <= periodLen;
        end else begin
            phase <= phase + 16'h0001;
        end
    end

    assign cycleStart = running && (phase == 16'h0000);

    logic [15:0] dmaxPoint;
    assign dmaxPoint = 16'((32'(curPeriod) * `CMPC_DMAX_NUM) / `CMPC_DMAX_DEN);

    // Soft-start duty ceiling grows with each step
    logic [15:0] softPoint;
    assign softPoint = 16'((32'(dmaxPoint) * 32'(ssStep)) / `CMPC_SS_STEPS);

    // ------------------------------------------------------------
    // Blanking and comparator gating
    // ------------------------------------------------------------
    logic [15:0] onPhase;
    logic [15:0] blankLen;
    logic        blanked;

    assign blankLen = burstS ? 16'(`CMPC_LEB_BURST_CYC) : 16'(`CMPC_LEB_NORM_CYC);
    assign blanked  = (onPhase < blankLen);

    logic peakHit;
    logic burstHit;
    logic fbHit;
    logic softHit;
    assign peakHit  = cmpS.peakTrip && !blanked;
    assign burstHit = cmpS.burstTrip && burstS && !blanked;
    assign fbHit    = cmpS.feedbackTrip && !blanked;
    assign softHit  = softActive && (phase >= softPoint);

    // ------------------------------------------------------------
    // PWM latch and gate
    // ------------------------------------------------------------
    logic [15:0] minOffCyc;
    logic        latch;
    logic        clearReq;
    assign minOffCyc = 16'(`CMPC_MINOFF_CYC);
    assign clearReq  = peakHit || burstHit || fbHit || softHit || (phase >= dmaxPoint);

    // latch set per cycle, comparators clear it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            latch <= 1'b0;
        end else if (!running) begin
            latch <= 1'b0;
        end else if (cycleStart) begin
            latch <= 1'b1;
        end else if (latch && clearReq) begin
            latch <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            onPhase <= 16'h0000;
        end else if (!gateDrive) begin
            onPhase <= 16'h0000;
        end else if (onPhase != 16'hffff) begin
            onPhase <= onPhase + 16'h0001;
        end
    end

    // gate held off for minimum delay
    // gate low under lockout
    // Clear terms act combinationally so the gate drops in the trip cycle
    assign gateDrive = running && supplyS && latch && (phase >= minOffCyc) && !clearReq;

    assign rampReset   = !latch;
    assign senseEnable = gateDrive && !blanked;

    // ------------------------------------------------------------
    // Analog control outputs
    // ------------------------------------------------------------
    // sense gain setting
    // soft level saturates once soft start ends
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            senseGainX100  <= 16'h0000;
            softStartLevel <= 6'h00;
        end else begin
            senseGainX100  <= 16'(`CMPC_GAIN_X100);
            softStartLevel <= softActive ? ssStep : (running ? 6'(`CMPC_SS_STEPS) : 6'h00);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status <= '0;
        end else begin
            status.softActive <= softActive;
            status.jitterOn   <= (state == CMPC_RUN);
            status.softStep   <= ssStep;
        end
    end

endmodule

// >>> rtl/cmpc_params.svh
// Timing and width constants for the current-mode PWM control core.
// Assumes a 10 MHz core clock; counts derive from the printed times.
`ifndef CMPC_PARAMS_SVH
`define CMPC_PARAMS_SVH

`define CMPC_CLK_HZ          10000000
`define CMPC_FSW_HZ          100000
`define CMPC_JITTER_PCT      4
`define CMPC_JITTER_MS       4
`define CMPC_DMAX_NUM        3
`define CMPC_DMAX_DEN        4
`define CMPC_MINOFF_NS       156
`define CMPC_SS_STEP_US      300
`define CMPC_SS_STEPS        32
`define CMPC_SS_TOTAL_MS     10
`define CMPC_LEB_NORM_NS     220
`define CMPC_LEB_BURST_NS    180
`define CMPC_GAIN_X100       325
`define CMPC_RAMP_X100       100

// Derived cycle counts (least times round up, none below one)
`define CMPC_PERIOD_CYC      (`CMPC_CLK_HZ / `CMPC_FSW_HZ)
`define CMPC_JIT_DEV_CYC     ((`CMPC_PERIOD_CYC * `CMPC_JITTER_PCT) / 100)
`define CMPC_JIT_HALF_CYC    ((`CMPC_JITTER_MS * (`CMPC_CLK_HZ / 1000)) / 2)
`define CMPC_MINOFF_CYC      ((`CMPC_MINOFF_NS * (`CMPC_CLK_HZ / 1000000) + 999) / 1000)
`define CMPC_LEB_NORM_CYC    ((`CMPC_LEB_NORM_NS * (`CMPC_CLK_HZ / 1000000) + 999) / 1000)
`define CMPC_LEB_BURST_CYC   ((`CMPC_LEB_BURST_NS * (`CMPC_CLK_HZ / 1000000) + 999) / 1000)
`define CMPC_SS_STEP_CYC     (`CMPC_SS_STEP_US * (`CMPC_CLK_HZ / 1000000))
`define CMPC_SS_TOTAL_CYC    (`CMPC_SS_TOTAL_MS * (`CMPC_CLK_HZ / 1000))

`endif

// >>> rtl/cmpc_pkg.sv
// Types shared by the current-mode PWM control core.
// Assumes the constants header is included alongside.
package cmpc_pkg;

    typedef enum logic [1:0] {
        CMPC_OFF,
        CMPC_SOFT,
        CMPC_RUN
    } cmpc_state_type;

    // Digital comparator results from the analog front end
    typedef struct packed {
        logic feedbackTrip;
        logic peakTrip;
        logic burstTrip;
    } cmpc_cmp_type;

    // Status outputs grouped for observation
    typedef struct packed {
        logic       softActive;
        logic       jitterOn;
        logic [5:0] softStep;
    } cmpc_stat_type;

endpackage

// >>> verif/cmpc_far_side.sv
// Behavioural switch, sense resistor and feedback path.
// Assumes each trip rises a set number of cycles into a pulse; 8'hff is never.
`timescale 1ns/10ps
module cmpc_far_side
    import cmpc_pkg::*;
(
    input wire logic       clock,
    input wire logic       gateDrive,
    input wire logic [7:0] fbAfter,
    input wire logic [7:0] pkAfter,
    input wire logic [7:0] bsAfter,
    output cmpc_cmp_type   cmpIn
);
    logic [7:0] onTime = 8'h00;
    // Current ramps while the switch conducts and is gone once it opens
    always_ff @(posedge clock) begin
        onTime <= gateDrive ? onTime + 8'h01 : 8'h00;
    end
    assign cmpIn.feedbackTrip = gateDrive && onTime >= fbAfter;
    assign cmpIn.peakTrip     = gateDrive && onTime >= pkAfter;
    assign cmpIn.burstTrip    = gateDrive && onTime >= bsAfter;
endmodule

// >>> verif/cmpc_pwm_asserts.sv
// Port-level checks of the PWM control core.
// Assumes one clock domain and the bench's shortened period.
`timescale 1ns/10ps
module cmpc_pwm_asserts
    import cmpc_pkg::*;
#(
    parameter int PERIOD_CYC = 20
) (
    input wire logic          clock,
    input wire logic          nrst,
    input wire logic          supplyOk,
    input wire logic          restartReq,
    input wire logic          burstMode,
    input wire cmpc_cmp_type  cmpIn,
    input wire logic          gateDrive,
    input wire logic          rampReset,
    input wire logic          senseEnable,
    input wire logic [5:0]    softStartLevel,
    input wire logic [15:0]   senseGainX100,
    input wire cmpc_stat_type status
);
    // Gate rises two cycles into the period, so two fewer than the limit
    localparam int MaxOn = PERIOD_CYC * 3 / 4 - 2;
    logic [7:0] onCount;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            onCount <= 8'h00;
        end else begin
            onCount <= gateDrive ? onCount + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Lockout and comparator paths pass a two-stage synchroniser first
    sequence s_supply_lost;
        !supplyOk [*4];
    endsequence
    // Trip seen twice has crossed the synchroniser; the gate must be gone next
    sequence s_peak_held;
        (cmpIn.peakTrip && senseEnable) ##1 cmpIn.peakTrip;
    endsequence
    sequence s_fb_held;
        (cmpIn.feedbackTrip && senseEnable) ##1 cmpIn.feedbackTrip;
    endsequence
    a_duty_limit: assert property (gateDrive |-> onCount < MaxOn)
        else $error("gate on beyond duty limit");
    a_min_off: assert property ($fell(rampReset) |-> !gateDrive)
        else $error("gate on without start delay");
    a_ramp_release: assert property (gateDrive |-> !rampReset)
        else $error("ramp held while gate on");
    a_gain_value: assert property ($past(nrst) |-> senseGainX100 == 16'h0145)
        else $error("sense gain wrong");
    a_lockout_off: assert property (s_supply_lost |=> !gateDrive && softStartLevel == 6'h00)
        else $error("gate or soft level alive in lockout");
    a_peak_kill: assert property (s_peak_held |=> !gateDrive)
        else $error("peak trip did not end pulse");
    a_fb_kill: assert property (s_fb_held |=> !gateDrive)
        else $error("feedback trip did not end pulse");
    a_blank_start: assert property ($rose(gateDrive) |-> !senseEnable [*2])
        else $error("sense enabled inside blanking");
    a_soft_nojit: assert property (status.softActive |-> !status.jitterOn)
        else $error("jitter on during soft start");
endmodule
bind cmpc_current_mode_pwm cmpc_pwm_asserts #(.PERIOD_CYC(PERIOD_CYC)) u_chk (
    .clock(clock), .nrst(nrst), .supplyOk(supplyOk), .restartReq(restartReq),
    .burstMode(burstMode), .cmpIn(cmpIn), .gateDrive(gateDrive), .rampReset(rampReset),
    .senseEnable(senseEnable), .softStartLevel(softStartLevel),
    .senseGainX100(senseGainX100), .status(status));

// >>> verif/testbench.sv
// Self-checking bench of the PWM control core.
// Assumes shortened counts: period 20, step 10, soft start 200 cycles.
`timescale 1ns/10ps
module testbench;
    import cmpc_pkg::*;
    logic          clock = 1'b0;
    logic          nrst = 1'b0;
    logic          supplyOk = 1'b0;
    logic          restartReq = 1'b0;
    logic          burstMode = 1'b0;
    logic [7:0]    fbAfter = 8'hff;
    logic [7:0]    pkAfter = 8'hff;
    logic [7:0]    bsAfter = 8'hff;
    cmpc_cmp_type  cmpIn;
    logic          gateDrive;
    logic          rampReset;
    logic          senseEnable;
    logic [5:0]    softStartLevel;
    logic [15:0]   senseGainX100;
    cmpc_stat_type status;
    int            err_total = 0;
    int            cmp_count = 0;
    int            lowLen;
    int            onLen;
    int            prevOn;
    logic [5:0]    lvl;
    always #50 clock = ~clock;
    cmpc_current_mode_pwm #(.PERIOD_CYC(20), .SS_STEP_CYC(10), .SS_TOTAL_CYC(200), .JIT_HALF_CYC(50)) uut (
        .clock(clock), .nrst(nrst), .supplyOk(supplyOk), .restartReq(restartReq),
        .burstMode(burstMode), .cmpIn(cmpIn), .gateDrive(gateDrive), .rampReset(rampReset),
        .senseEnable(senseEnable), .softStartLevel(softStartLevel),
        .senseGainX100(senseGainX100), .status(status));
    cmpc_far_side far (.clock(clock), .gateDrive(gateDrive), .fbAfter(fbAfter),
        .pkAfter(pkAfter), .bsAfter(bsAfter), .cmpIn(cmpIn));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Low span before the next pulse and that pulse's length
    task automatic pulse();
        prevOn = onLen;
        while (gateDrive === 1'b1 && lowLen < 400) begin
            @(negedge clock);
        end
        lowLen = 0;
        while (gateDrive !== 1'b1 && lowLen < 400) begin
            @(negedge clock);
            lowLen++;
        end
        onLen = 0;
        while (gateDrive === 1'b1 && onLen < 400) begin
            @(negedge clock);
            onLen++;
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_up();
        repeat (20) @(negedge clock);
        chk(gateDrive, 1'b0);
        chk(softStartLevel, 6'h00);
        chk(senseGainX100, 16'h0145);
        @(posedge clock);
        supplyOk <= 1'b1;
        repeat (60) @(negedge clock);
        chk(status.softActive, 1'b1);
        chk(status.jitterOn, 1'b0);
        lvl = softStartLevel;
        repeat (20) @(negedge clock);
        chk(softStartLevel, lvl + 6'h02);
        repeat (200) @(negedge clock);
        chk(status.softActive, 1'b0);
        chk(softStartLevel, 6'h20);
        chk(status.jitterOn, 1'b1);
        $display("power-up test done");
    endtask
    task automatic t_run_pulse();
        pulse();
        pulse();
        chk(prevOn + lowLen, 20);
        chk(onLen, 13);
        $display("run pulse test done");
    endtask
    task automatic t_trips();
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            fbAfter <= (i == 0) ? 8'h05 : 8'hff;
            pkAfter <= (i == 1) ? 8'h05 : 8'hff;
            bsAfter <= (i == 2) ? 8'h05 : 8'hff;
            burstMode <= (i == 2);
            pulse();
            pulse();
            chk(onLen, 7);
        end
        @(posedge clock);
        burstMode <= 1'b0;
        pulse();
        pulse();
        chk(onLen, 13);
        @(posedge clock);
        bsAfter <= 8'hff;
        pkAfter <= 8'h00;
        pulse();
        pulse();
        lvl = onLen[5:0];
        @(posedge clock);
        burstMode <= 1'b1;
        pulse();
        pulse();
        chk(lvl - onLen[5:0], 6'h01);
        chk(onLen > 1, 1'b1);
        @(posedge clock);
        pkAfter <= 8'hff;
        burstMode <= 1'b0;
        $display("trip test done");
    endtask
    task automatic t_restart_uvlo();
        @(posedge clock);
        restartReq <= 1'b1;
        repeat (3) @(posedge clock);
        restartReq <= 1'b0;
        repeat (8) @(negedge clock);
        chk(status.softActive, 1'b1);
        chk(softStartLevel < 6'h20, 1'b1);
        @(posedge clock);
        supplyOk <= 1'b0;
        repeat (6) @(negedge clock);
        chk(gateDrive, 1'b0);
        chk(softStartLevel, 6'h00);
        $display("restart and lockout test done");
    endtask
    initial begin
        #(100 * 5000);
        err_total++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        t_power_up();
        t_run_pulse();
        t_trips();
        t_restart_uvlo();
        conclude();
    end
endmodule
